// ### verilog/clock_out_divider_irq_enable.sv
// Oscillator interrupt enables and divided external clock output behind an APB slave.
//
// Functional notes
// [RL1] The enable register holds a readable low-speed stop and an internal trim-done enable.
// [RL2] Enable bits 2, 1 and 0 enable the high-speed, low-speed and internal stable interrupts.
// [RL3] Control bits 3-2 pick the output source: internal, low-speed, high-speed or system clock.
// [RL4] Control bits 6-4 divide the internal or high-speed source by two to the field's power.
// [RL5] Low-speed codes 4 to 7 divide by 256 to 32768 and the system clock allows only code 0.
// [RL6] With the system clock selected the output stops while standby stops that clock.
// [RL7] Control bit 0 gates the divided clock onto the output pin and reads back.
// [RL8] The gate acts without alignment to the divided clock, so a short pulse can appear.
// [RL9] Reserved bits read as zero, ignore writes, and all fields clear on reset.
`timescale 1ns/10ps
module clock_out_divider_irq_enable
  import clkout_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources, sampled as plain levels.
  input wire logic internal_osc_clock,
  input wire logic lowspeed_osc_clock,
  input wire logic highspeed_osc_clock,
  input wire logic system_clock,
  // Standby state from the power controller.
  input wire logic standby_active,
  // Oscillator event pulses.
  input wire logic lowspeed_stop_event,
  input wire logic internal_trim_done_event,
  input wire logic highspeed_stable_event,
  input wire logic lowspeed_stable_event,
  input wire logic internal_stable_event,
  // Per-source interrupt enables.
  output logic lowspeed_stop_irq_en,
  output logic internal_trim_done_irq_en,
  output logic highspeed_stable_irq_en,
  output logic lowspeed_stable_irq_en,
  output logic internal_stable_irq_en,
  // Interrupt and clock output.
  output logic irq,
  output logic clock_output_pin
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [15:0] inte_q;
  logic [15:0] inte_d;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic irq_q;
  logic irq_d;
  logic pin_q;
  logic pin_d;
  logic [15:0] event_vec;
  logic [15:0] clear_vec;
  logic [15:0] rd_word;
  logic setup_phase;
  logic wr_take;
  logic addr_hit;
  logic [3:0] src_sync;
  logic [1:0] src_sel;
  logic [2:0] div_sel;
  logic [3:0] div_exp;
  logic reserved_code;
  logic hold;
  logic src_level;
  logic div_out;
  logic gate;
  logic [15:0] wdata_lo;

  // ----------------------------------------------------------------
  // APB slave.
  // ----------------------------------------------------------------
  assign setup_phase = psel && !penable;
  assign wr_take = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wdata_lo = pwdata[15:0];

  always_comb begin
    addr_hit = 1'b1;
    rd_word = 16'h0000;
    case (paddr)
      IRQ_ENABLE_OFFSET: begin
        rd_word = inte_q & IRQ_BITS_MASK; // [RL1] [RL2] [RL9]
      end
      CLOCK_OUT_OFFSET: begin
        rd_word = ctrl_q & CTRL_BITS_MASK; // [RL7] [RL9]
      end
      IRQ_STATUS_OFFSET: begin
        rd_word = status_q & IRQ_BITS_MASK;
      end
      IRQ_CLEAR_OFFSET: begin
        rd_word = 16'h0000;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    pready_d = setup_phase;
    pslverr_d = setup_phase && !addr_hit;
    prdata_d = prdata_q;
    if (setup_phase) begin
      prdata_d = (pwrite || !addr_hit) ? 32'h0000_0000 : {16'h0000, rd_word};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Registers and interrupt status.
  // ----------------------------------------------------------------
  always_comb begin
    event_vec = 16'h0000;
    event_vec[LS_STOP_BIT] = lowspeed_stop_event;
    event_vec[TRIM_DONE_BIT] = internal_trim_done_event;
    event_vec[HS_STABLE_BIT] = highspeed_stable_event;
    event_vec[LS_STABLE_BIT] = lowspeed_stable_event;
    event_vec[INT_STABLE_BIT] = internal_stable_event;
  end

  always_comb begin
    inte_d = inte_q;
    ctrl_d = ctrl_q;
    clear_vec = 16'h0000;
    if (wr_take) begin
      case (paddr)
        IRQ_ENABLE_OFFSET: begin
          inte_d = wdata_lo & IRQ_BITS_MASK; // [RL1] [RL2] [RL9]
        end
        CLOCK_OUT_OFFSET: begin
          ctrl_d = wdata_lo & CTRL_BITS_MASK; // [RL3] [RL7] [RL9]
        end
        IRQ_CLEAR_OFFSET: begin
          clear_vec = wdata_lo & IRQ_BITS_MASK;
        end
        default: begin
          clear_vec = 16'h0000;
        end
      endcase
    end
    status_d = (status_q & ~clear_vec) | event_vec;
    irq_d = |(status_d & inte_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inte_q <= IRQ_ENABLE_RESET; // [RL9]
      ctrl_q <= CTRL_RESET; // [RL9]
      status_q <= IRQ_STATUS_RESET;
      irq_q <= 1'b0;
    end else begin
      inte_q <= inte_d;
      ctrl_q <= ctrl_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign lowspeed_stop_irq_en = inte_q[LS_STOP_BIT]; // [RL1]
  assign internal_trim_done_irq_en = inte_q[TRIM_DONE_BIT]; // [RL1]
  assign highspeed_stable_irq_en = inte_q[HS_STABLE_BIT]; // [RL2]
  assign lowspeed_stable_irq_en = inte_q[LS_STABLE_BIT]; // [RL2]
  assign internal_stable_irq_en = inte_q[INT_STABLE_BIT]; // [RL2]
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Clock output path.
  // ----------------------------------------------------------------
  bit_sync #(
    .W(4)
  ) u_src_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({system_clock, highspeed_osc_clock, lowspeed_osc_clock, internal_osc_clock}),
    .sync_out(src_sync)
  );

  assign src_sel = ctrl_q[SRC_MSB:SRC_LSB];
  assign div_sel = ctrl_q[DIV_MSB:DIV_LSB];
  assign gate = ctrl_q[GATE_BIT];
  assign src_level = src_sync[src_sel]; // [RL3]
  assign hold = (src_sel == SRC_SYSTEM) && standby_active; // [RL6]

  always_comb begin
    div_exp = {1'b0, div_sel}; // [RL4]
    reserved_code = 1'b0;
    case (src_sel)
      SRC_LOWSPEED: begin
        if (div_sel[2]) begin
          case (div_sel[1:0])
            2'h0: div_exp = LS_EXP_256; // [RL5]
            2'h1: div_exp = LS_EXP_1024; // [RL5]
            2'h2: div_exp = LS_EXP_4096; // [RL5]
            default: div_exp = LS_EXP_32768; // [RL5]
          endcase
        end
      end
      SRC_SYSTEM: begin
        div_exp = 4'h0;
        reserved_code = (div_sel != 3'h0); // [RL5]
      end
      default: begin
        div_exp = {1'b0, div_sel};
      end
    endcase
  end

  clkout_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .src_level(src_level),
    .div_exp(div_exp),
    .hold(hold),
    .div_out(div_out)
  );

  // The gate is applied straight to the divided level with no alignment.
  assign pin_d = gate && div_out && !reserved_code; // [RL7] [RL8]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign clock_output_pin = pin_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_enable_write;
    wr_take && (paddr == IRQ_ENABLE_OFFSET);
  endsequence

  sequence s_ctrl_write;
    wr_take && (paddr == CLOCK_OUT_OFFSET);
  endsequence

  sequence s_standby_steady;
    (hold && $stable(ctrl_q)) [*4];
  endsequence

  a_enable_store: assert property (s_enable_write |=> inte_q == ($past(wdata_lo) & IRQ_BITS_MASK)) // [RL1]
    else $error("Enable register did not take the written value.");

  a_stable_enables: assert property (s_enable_write |=> // [RL2]
      {13'h0000, highspeed_stable_irq_en, lowspeed_stable_irq_en, internal_stable_irq_en}
      == ($past(wdata_lo) & 16'h0007))
    else $error("Stable interrupt enables do not match the write.");

  a_ctrl_store: assert property (s_ctrl_write |=> ctrl_q == ($past(wdata_lo) & CTRL_BITS_MASK)) // [RL3]
    else $error("Control register did not take the written value.");

  a_reserved_zero: assert property (pready_q |-> // [RL9]
      (prdata_q[15:0] & ~(IRQ_BITS_MASK | CTRL_BITS_MASK)) == 16'h0000
      && prdata_q[31:16] == 16'h0000)
    else $error("Reserved read bits are not zero.");

  a_div_plain: assert property ((src_sel == SRC_HIGHSPEED || src_sel == SRC_INTERNAL) // [RL4]
      |-> div_exp == {1'b0, div_sel})
    else $error("Divider exponent wrong for internal or high-speed source.");

  a_lowspeed_top: assert property ((src_sel == SRC_LOWSPEED && div_sel == 3'h7) // [RL5]
      |-> div_exp == LS_EXP_32768)
    else $error("Low-speed top code does not divide by 32768.");

  a_sys_reserved: assert property ((src_sel == SRC_SYSTEM && div_sel != 3'h0) // [RL5]
      |=> !clock_output_pin)
    else $error("Reserved system clock code drives the output.");

  a_standby_stop: assert property (s_standby_steady |-> $stable(clock_output_pin)) // [RL6]
    else $error("Output moved while the system clock was stopped.");

  a_gate_off: assert property (!gate [*2] |-> !clock_output_pin) // [RL7]
    else $error("Output active while the gate is off.");

  a_gate_immediate: assert property ($rose(gate) && !reserved_code // [RL8]
      |=> clock_output_pin == $past(div_out))
    else $error("Gate did not act on the next edge.");

  a_set_wins: assert property (lowspeed_stop_event && clear_vec[LS_STOP_BIT]
      |=> status_q[LS_STOP_BIT])
    else $error("Event lost against a clear.");

  a_irq_follow: assert property (irq == |(status_q & inte_q))
    else $error("Interrupt output does not track enabled status.");

endmodule

// ### verilog/clkout_pkg.sv
// Register map, field layout and encodings of the clock output and oscillator interrupt block.
package clkout_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h00;
  localparam logic [7:0] CLOCK_OUT_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h0c;

  // ----------------------------------------------------------------
  // Interrupt enable, status and clear layout.
  // ----------------------------------------------------------------
  localparam int INT_STABLE_BIT = 0;
  localparam int LS_STABLE_BIT = 1;
  localparam int HS_STABLE_BIT = 2;
  localparam int TRIM_DONE_BIT = 4;
  localparam int LS_STOP_BIT = 5;
  localparam logic [15:0] IRQ_BITS_MASK = 16'h0037;
  localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Clock output control layout.
  // ----------------------------------------------------------------
  localparam int GATE_BIT = 0;
  localparam int SRC_LSB = 2;
  localparam int SRC_MSB = 3;
  localparam int DIV_LSB = 4;
  localparam int DIV_MSB = 6;
  localparam logic [15:0] CTRL_BITS_MASK = 16'h007d;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Source codes and divider exponents.
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_LOWSPEED = 2'h1;
  localparam logic [1:0] SRC_HIGHSPEED = 2'h2;
  localparam logic [1:0] SRC_SYSTEM = 2'h3;
  localparam logic [3:0] LS_EXP_256 = 4'h8;
  localparam logic [3:0] LS_EXP_1024 = 4'ha;
  localparam logic [3:0] LS_EXP_4096 = 4'hc;
  localparam logic [3:0] LS_EXP_32768 = 4'hf;
  localparam int DIV_CNT_W = 15;

endpackage

// ### verilog/bit_sync.sv
// Two-stage synchroniser for levels arriving from outside the pclk domain.
`timescale 1ns/10ps
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule

// ### verilog/clkout_divider.sv
// Power-of-two divider counting rising edges of a sampled source clock.
`timescale 1ns/10ps
module clkout_divider
  import clkout_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Source level, exponent and freeze.
  input wire logic src_level,
  input wire logic [3:0] div_exp,
  input wire logic hold,
  // Divided level.
  output logic div_out
);

  logic src_last_q;
  logic src_last_d;
  logic [DIV_CNT_W-1:0] cnt_q;
  logic [DIV_CNT_W-1:0] cnt_d;
  logic div_q;
  logic div_d;

  always_comb begin
    src_last_d = hold ? src_last_q : src_level;
    cnt_d = cnt_q;
    if (!hold && src_level && !src_last_q) begin
      cnt_d = cnt_q + {{(DIV_CNT_W-1){1'b0}}, 1'b1};
    end
    if (hold) begin
      div_d = div_q;
    end else if (div_exp == 4'h0) begin
      div_d = src_level;
    end else begin
      div_d = cnt_d[div_exp - 4'h1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_last_q <= 1'b0;
      cnt_q <= '0;
      div_q <= 1'b0;
    end else begin
      src_last_q <= src_last_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
    end
  end

  assign div_out = div_q;

endmodule

// ### verif/clkout_receiver.sv
// Far-side model that times the rising edges arriving on the clock output pin.
`timescale 1ns/10ps
module clkout_receiver (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pin and count clear.
  input wire logic pin,
  input wire logic clr,
  // Last period in pclk cycles and rising edge count.
  output logic [15:0] period,
  output logic [15:0] rises
);
  logic pin_q;
  logic [15:0] cnt;
  // Every rise outside a clear cycle is counted, short ones too, since the gate may cut a pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      cnt <= 16'h0000;
      period <= 16'h0000;
      rises <= 16'h0000;
    end else begin
      pin_q <= pin;
      cnt <= cnt + 16'h0001;
      if (clr) begin
        rises <= 16'h0000;
        cnt <= 16'h0000;
      end else if (pin && !pin_q) begin
        rises <= rises + 16'h0001;
        period <= cnt + 16'h0001;
        cnt <= 16'h0000;
      end
    end
  end
endmodule

// ### verif/clock_out_divider_irq_enable_tb.sv
// Self-checking bench for the clock output and oscillator interrupt block.
`timescale 1ns/10ps
module clock_out_divider_irq_enable_tb;
  import clkout_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, irq, pin, standby = 1'b0, clr = 1'b0;
  logic i_clk = 1'b0, l_clk = 1'b0, h_clk = 1'b0, s_clk = 1'b0;
  logic [5:0] ev = 6'h00;
  wire [5:0] en;
  logic [7:0] tick = 8'h00;
  logic [15:0] period, rises;
  int failures = 0, compares = 0, cycles = 0;

  // ----------------------------------------------------------------
  // Clock, sources and instances.
  // ----------------------------------------------------------------
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tick <= (tick == 8'd59) ? 8'h00 : tick + 8'h01;
    i_clk <= (tick % 4) >= 2;
    l_clk <= (tick % 4) == 1 || (tick % 4) == 2;
    h_clk <= (tick % 6) >= 3;
    s_clk <= (tick % 10) >= 5;
  end
  clock_out_divider_irq_enable u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_osc_clock(i_clk),
    .lowspeed_osc_clock(l_clk), .highspeed_osc_clock(h_clk), .system_clock(s_clk),
    .standby_active(standby), .lowspeed_stop_event(ev[5]),
    .internal_trim_done_event(ev[4]), .highspeed_stable_event(ev[2]),
    .lowspeed_stable_event(ev[1]), .internal_stable_event(ev[0]),
    .lowspeed_stop_irq_en(en[5]), .internal_trim_done_irq_en(en[4]),
    .highspeed_stable_irq_en(en[2]), .lowspeed_stable_irq_en(en[1]),
    .internal_stable_irq_en(en[0]), .irq(irq), .clock_output_pin(pin));
  assign en[3] = 1'b0;
  clkout_receiver u_rx (.pclk(pclk), .presetn(presetn), .pin(pin), .clr(clr),
    .period(period), .rises(rises));

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 6'h00;
    @(posedge pclk);
    #1;
  endtask
  task automatic watch(input int n);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, IRQ_ENABLE_OFFSET, 32'h0000_0000);
    check("enable reset", 32'h0000_0000, rd);
    apb(1'b0, CLOCK_OUT_OFFSET, 32'h0000_0000);
    check("control reset", 32'h0000_0000, rd);
    apb(1'b1, IRQ_ENABLE_OFFSET, 32'hffff_ffff);
    apb(1'b0, IRQ_ENABLE_OFFSET, 32'h0000_0000);
    check("enable readback", 32'h0000_0037, rd);
    check("mapped read err", 32'h0000_0000, {31'h0, err});
    check("enable pins", 32'h0000_0037, {26'h0, en});
    apb(1'b1, CLOCK_OUT_OFFSET, 32'hffff_ffff);
    apb(1'b0, CLOCK_OUT_OFFSET, 32'h0000_0000);
    check("control readback", 32'h0000_007d, rd);
    apb(1'b1, 8'h40, 32'hffff_ffff);
    check("unmapped write err", 32'h0000_0001, {31'h0, err});
    apb(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped read", 32'h0000_0001, {31'h0, err});
    check("unmapped data", 32'h0000_0000, rd);
    apb(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0000);
    check("enable cleared", 32'h0000_0000, {26'h0, en});
  endtask
  task automatic t_irq();
    int bits[5] = '{0, 1, 2, 4, 5};
    logic [5:0] m;
    foreach (bits[i]) begin
      m = 6'h01 << bits[i];
      apb(1'b1, IRQ_ENABLE_OFFSET, {26'h0, m});
      pulse(m);
      check("irq enabled", 32'h0000_0001, {31'h0, irq});
      apb(1'b0, IRQ_STATUS_OFFSET, 32'h0000_0000);
      check("status", {26'h0, m}, rd);
      apb(1'b1, IRQ_CLEAR_OFFSET, {26'h0, m});
      #1;
      check("irq cleared", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, IRQ_ENABLE_OFFSET, {26'h0, ~m & 6'h37});
      pulse(m);
      check("irq masked", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, IRQ_CLEAR_OFFSET, {26'h0, m});
    end
    fork
      apb(1'b1, IRQ_CLEAR_OFFSET, 32'h0000_0020);
      begin
        repeat (2) @(posedge pclk);
        ev <= 6'h20;
        @(posedge pclk);
        ev <= 6'h00;
      end
    join
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0000_0000);
    check("set beats clear", 32'h0000_0020, rd);
    apb(1'b1, IRQ_CLEAR_OFFSET, 32'h0000_0020);
  endtask
  task automatic t_clock();
    int src[7] = '{0, 0, 0, 2, 1, 1, 3};
    int dv[7] = '{0, 3, 7, 7, 3, 4, 0};
    int per[7] = '{4, 32, 512, 768, 32, 1024, 10};
    foreach (src[i]) begin
      apb(1'b1, CLOCK_OUT_OFFSET, 32'h0000_0001 | (dv[i] << 4) | (src[i] << 2));
      watch(3 * per[i] + 20);
      check("period", per[i], {16'h0, period});
      check("rises seen", 32'h0000_0001, {31'h0, rises >= 16'd2});
    end
    apb(1'b1, CLOCK_OUT_OFFSET, 32'h0000_0075);
    apb(1'b0, CLOCK_OUT_OFFSET, 32'h0000_0000);
    check("control lowspeed top", 32'h0000_0075, rd);
  endtask
  task automatic t_stops();
    apb(1'b1, CLOCK_OUT_OFFSET, 32'h0000_000d);
    @(posedge pclk);
    standby <= 1'b1;
    watch(100);
    check("standby rises", 32'h0000_0000, {16'h0, rises});
    @(posedge pclk);
    standby <= 1'b0;
    watch(60);
    check("wake rises", 32'h0000_0001, {31'h0, rises >= 16'd4});
    apb(1'b1, CLOCK_OUT_OFFSET, 32'h0000_001d);
    watch(100);
    check("reserved rises", 32'h0000_0000, {16'h0, rises});
    check("reserved pin", 32'h0000_0000, {31'h0, pin});
    apb(1'b1, CLOCK_OUT_OFFSET, 32'h0000_0001);
    apb(1'b1, CLOCK_OUT_OFFSET, 32'h0000_0000);
    watch(60);
    check("gated rises", 32'h0000_0000, {16'h0, rises});
    check("gated pin", 32'h0000_0000, {31'h0, pin});
    apb(1'b1, CLOCK_OUT_OFFSET, 32'h0000_0001);
    watch(20);
    check("regated rises", 32'h0000_0001, {31'h0, rises >= 16'd3});
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check("irq after reset", 32'h0000_0000, {31'h0, irq});
    check("pin after reset", 32'h0000_0000, {31'h0, pin});
    t_regs();
    t_irq();
    t_clock();
    t_stops();
    close_out();
  end
endmodule
